// >>> rtl/pbac_defs.svh
/*
 constants of the bus-access control block: register offsets, field positions, reset value,
 write mask, bus command codes, cache-line sizes and poll times.
 assumes it is included by its bare name; the include guard lets it be included more than once per compile unit.
*/
`ifndef PBAC_DEFS_SVH
`define PBAC_DEFS_SVH

// register space
`define PBAC_OFS_ACCESS      8'h00
`define PBAC_OFS_STRIDE_LO   8'h08
`define PBAC_OFS_STRIDE_HI   8'h04
`define PBAC_OFS_HI_BASE     8'h80
`define PBAC_ACCESS_RST      32'h0000_0000
`define PBAC_ACCESS_WMASK    32'h01a6_ff00

// field positions in bus_access_control
`define PBAC_WIE_BIT         24
`define PBAC_RLE_BIT         23
`define PBAC_RME_BIT         21
`define PBAC_POLL_MSB        18
`define PBAC_POLL_LSB        17
`define PBAC_ALIGN_MSB       15
`define PBAC_ALIGN_LSB       14
`define PBAC_BURST_MSB       13
`define PBAC_BURST_LSB       8

// field codes
`define PBAC_POLL_OFF        2'h0
`define PBAC_POLL_SHORT      2'h1
`define PBAC_POLL_MID        2'h2
`define PBAC_ALIGN_NONE      2'h0
`define PBAC_ALIGN_8         2'h1
`define PBAC_ALIGN_16        2'h2
`define PBAC_BURST_NOLIMIT   6'h00

// cache-line lengths in doublewords
`define PBAC_LINE_NONE       6'h00
`define PBAC_LINE_8          6'h08
`define PBAC_LINE_16         6'h10
`define PBAC_LINE_32         6'h20

// bus commands
`define PBAC_CMD_MR          4'h6
`define PBAC_CMD_MW          4'h7
`define PBAC_CMD_MRM         4'hc
`define PBAC_CMD_MRL         4'he
`define PBAC_CMD_MWI         4'hf

// poll intervals
`define PBAC_CLK_MHZ         100
`define PBAC_POLL_SHORT_US   200
`define PBAC_POLL_MID_US     800
`define PBAC_POLL_LONG_US    1600

// widths
`define PBAC_LEN_W           16
`define PBAC_POLL_CNT_W      18
`define PBAC_FIFO_DEPTH      4

`endif

// >>> rtl/pbac_fifo.sv
/*
 small shift-register fifo with valid/ready on both sides.
 head entry, out_valid and in_ready are flip-flops so a top level can drive ports from them.
 assumes one clock, asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module pbac_fifo #(
   parameter int WIDTH = 52,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output var  logic             out_valid,
   input  wire logic             out_ready,
   output var  logic [WIDTH-1:0] out_data
);

   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [CW-1:0]               count;
      logic                        out_valid;
      logic                        in_ready;
   } pbac_fifo_st_t;

   pbac_fifo_st_t st;
   pbac_fifo_st_t next_st;

   always_comb begin
      logic          push;
      logic          pop;
      logic [CW-1:0] wr_idx;
      next_st = st;
      push    = in_valid && st.in_ready;
      pop     = st.out_valid && out_ready;
      wr_idx  = st.count;
      if (pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            next_st.mem[i] = st.mem[i+1];
         end
         wr_idx = st.count - CW'(1);
      end
      if (push) begin
         next_st.mem[wr_idx] = in_data;
      end
      next_st.count     = wr_idx + (push ? CW'(1) : CW'(0));
      next_st.out_valid = (next_st.count != CW'(0));
      next_st.in_ready  = (next_st.count != CW'(DEPTH));
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign in_ready  = st.in_ready;
   assign out_valid = st.out_valid;
   assign out_data  = st.mem[0];

endmodule : pbac_fifo

`default_nettype wire

// >>> rtl/pbac_pkg.sv
/*
 types shared by the bus-access control block: engine states and the burst word.
 assumes pbac_defs.svh is on the include path.
*/
`include "pbac_defs.svh"

package pbac_pkg;

   typedef enum logic [1:0] {
      PBAC_IDLE,
      PBAC_RUN
   } pbac_state_t;

   typedef struct packed {
      logic [3:0]             cmd;
      logic [31:0]            addr;
      logic [`PBAC_LEN_W-1:0] len;
   } pbac_burst_t;

endpackage : pbac_pkg

// >>> rtl/pbac_top.sv
/*
 bus-access control for the bus-master dma engine: the bus_access_control register,
 the splitter that cuts dma requests into bursts with the right memory command,
 and the transmit auto-poll timer.
 assumes: csr accesses come synchronous to clk with a one-cycle strobe; the descriptor
 engine offers doubleword-aligned requests; the bus master drains bursts with valid/ready.
*/
// Contract
// - with write-invalidate enabled, a dma write covering a whole cache line uses memory write and invalidate.
// - with write-invalidate disabled, every dma write uses plain memory write and never write-invalidate.
// - with read-line enabled, a dma read reaching a cache-line boundary uses memory read line (read multiple if enabled and a full line), else plain read.
// - with read-multiple enabled, a dma read of a full cache line uses read multiple, unaligned ones plain read or, with read-line, read line at a line end.
// - while transmit is suspended the next descriptor is polled every 200, 800 or 1600 us, or never for code 00.
// - bursts are cut at 8, 16 or 32 doubleword boundaries per the alignment field, code 00 meaning no boundary cut.
// - no dma transaction exceeds the burst-length field in doublewords, zero meaning no limit.
// - the access register is decoded at offset 0x00 of the control/status space.
`timescale 1ns/1ps
`default_nettype none

`include "pbac_defs.svh"

module pbac_top #(
   parameter int POLL_SHORT_CYC = `PBAC_POLL_SHORT_US * `PBAC_CLK_MHZ,
   parameter int POLL_MID_CYC   = `PBAC_POLL_MID_US * `PBAC_CLK_MHZ,
   parameter int POLL_LONG_CYC  = `PBAC_POLL_LONG_US * `PBAC_CLK_MHZ
) (
   input  wire logic                   clk,
   input  wire logic                   nrst,
   // control/status space
   input  wire logic                   csr_sel,
   input  wire logic                   csr_wr,
   input  wire logic [7:0]             csr_addr,
   input  wire logic [3:0]             csr_be,
   input  wire logic [31:0]            csr_wdata,
   output var  logic [31:0]            csr_rdata,
   output var  logic                   csr_ack,
   // dma requests from the descriptor engine
   input  wire logic                   req_valid,
   output var  logic                   req_ready,
   input  wire logic                   req_write,
   input  wire logic [31:0]            req_addr,
   input  wire logic [`PBAC_LEN_W-1:0] req_len,
   output var  logic                   req_done,
   // bursts toward the bus master
   output var  logic                   bst_valid,
   input  wire logic                   bst_ready,
   output var  logic [3:0]             bst_cmd,
   output var  logic [31:0]            bst_addr,
   output var  logic [`PBAC_LEN_W-1:0] bst_len,
   // transmit auto-poll
   input  wire logic                   tx_suspended,
   output var  logic                   tx_poll
);

   import pbac_pkg::*;

   typedef struct packed {
      logic [31:0]                  access;
      pbac_state_t                  state;
      logic                         write;
      logic [31:0]                  addr;
      logic [`PBAC_LEN_W-1:0]       rem;
      logic                         wie;
      logic                         rle;
      logic                         rme;
      logic [5:0]                   line;
      logic [5:0]                   burst;
      logic                         req_ready;
      logic                         req_done;
      logic [31:0]                  rdata;
      logic                         ack;
      logic [`PBAC_POLL_CNT_W-1:0]  poll_cnt;
      logic [1:0]                   poll_code;
      logic                         poll;
   } pbac_top_st_t;

   pbac_top_st_t st;
   pbac_top_st_t next_st;

   pbac_burst_t  push_word;
   logic         push_valid;
   logic         push_ready;
   pbac_burst_t  head_word;
   logic         head_valid;

   function automatic logic [5:0] line_of(input logic [1:0] code);
      case (code)
         `PBAC_ALIGN_8:  line_of = `PBAC_LINE_8;
         `PBAC_ALIGN_16: line_of = `PBAC_LINE_16;
         `PBAC_ALIGN_NONE: line_of = `PBAC_LINE_NONE;
         default:        line_of = `PBAC_LINE_32;
      endcase
   endfunction : line_of

   function automatic logic [`PBAC_LEN_W-1:0] min_len(input logic [`PBAC_LEN_W-1:0] a,
                                                     input logic [`PBAC_LEN_W-1:0] b);
      min_len = (a < b) ? a : b;
   endfunction : min_len

   function automatic logic [`PBAC_POLL_CNT_W-1:0] poll_limit(input logic [1:0] code);
      case (code)
         `PBAC_POLL_SHORT: poll_limit = `PBAC_POLL_CNT_W'(POLL_SHORT_CYC - 1);
         `PBAC_POLL_MID:   poll_limit = `PBAC_POLL_CNT_W'(POLL_MID_CYC - 1);
         default:          poll_limit = `PBAC_POLL_CNT_W'(POLL_LONG_CYC - 1);
      endcase
   endfunction : poll_limit

   // byte lanes of a register write; bytes left out keep their old contents
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         lane_mask[i*8 +: 8] = {8{be[i]}};
      end
   endfunction : lane_mask

   // doubleword offset of an address inside its cache line; zero when no line is set
   function automatic logic [5:0] line_offset(input logic [31:0] a, input logic [5:0] line);
      if (line == `PBAC_LINE_NONE) begin
         line_offset = 6'h00;
      end else begin
         line_offset = {1'b0, a[6:2]} & (line - 6'h01);
      end
   endfunction : line_offset

   // length of the next burst: the remainder, cut at the line end and at the burst limit
   function automatic logic [`PBAC_LEN_W-1:0] next_chunk(input logic [`PBAC_LEN_W-1:0] rem,
                                                        input logic [`PBAC_LEN_W-1:0] to_end,
                                                        input logic [5:0]             line,
                                                        input logic [5:0]             burst);
      next_chunk = rem;
      if (line != `PBAC_LINE_NONE) begin
         next_chunk = min_len(next_chunk, to_end);
      end
      if (burst != `PBAC_BURST_NOLIMIT) begin
         next_chunk = min_len(next_chunk, `PBAC_LEN_W'(burst));
      end
   endfunction : next_chunk

   // write command: write-invalidate only for a whole, aligned line
   function automatic logic [3:0] write_cmd(input logic wie, input logic full);
      if (wie && full) begin
         write_cmd = `PBAC_CMD_MWI;
      end else begin
         write_cmd = `PBAC_CMD_MW;
      end
   endfunction : write_cmd

   // read command: a full line beats a line end; anything else is a plain read
   function automatic logic [3:0] read_cmd(input logic rme,
                                           input logic rle,
                                           input logic full,
                                           input logic hits);
      if (rme && full) begin
         read_cmd = `PBAC_CMD_MRM;
      end else if (rle && hits) begin
         read_cmd = `PBAC_CMD_MRL;
      end else begin
         read_cmd = `PBAC_CMD_MR;
      end
   endfunction : read_cmd

   // burst cut and command choice, all from the settings latched at request start
   logic [`PBAC_LEN_W-1:0] to_line;
   logic [`PBAC_LEN_W-1:0] chunk;
   logic [5:0]             line_ofs;
   logic                   line_start;
   logic                   full_line;
   logic                   hits_line;
   logic [3:0]             cmd;

   always_comb begin
      line_ofs   = line_offset(st.addr, st.line);
      to_line    = `PBAC_LEN_W'(st.line - line_ofs);
      chunk      = next_chunk(st.rem, to_line, st.line, st.burst);
      line_start = (st.line != `PBAC_LINE_NONE) && (line_ofs == 6'h00);
      full_line  = line_start && (chunk == `PBAC_LEN_W'(st.line));
      hits_line  = (st.line != `PBAC_LINE_NONE) && (chunk == to_line);
      if (st.write) begin
         cmd = write_cmd(st.wie, full_line);
      end else begin
         cmd = read_cmd(st.rme, st.rle, full_line, hits_line);
      end
      push_word.cmd  = cmd;
      push_word.addr = st.addr;
      push_word.len  = chunk;
      push_valid     = (st.state == PBAC_RUN);
   end

   always_comb begin
      logic [31:0] lane;
      logic [31:0] wmask;
      logic        hit;
      lane    = lane_mask(csr_be);
      wmask   = lane & `PBAC_ACCESS_WMASK;
      hit     = csr_sel && (csr_addr == `PBAC_OFS_ACCESS);
      next_st = st;

      // register port: one-cycle ack, other offsets read zero and ignore writes
      next_st.ack   = csr_sel;
      next_st.rdata = 32'h0000_0000;
      // reads ignore byte enables and return the whole word
      if (hit && csr_wr) begin
         // restricted fields are written blindly; software stops dma first
         next_st.access = (st.access & ~wmask) | (csr_wdata & wmask);
      end
      if (hit && !csr_wr) begin
         next_st.rdata = st.access;
      end

      // splitter
      next_st.req_done = 1'b0;
      case (st.state)
         PBAC_IDLE: begin
            if (req_valid && st.req_ready && (req_len != `PBAC_LEN_W'(0))) begin
               next_st.state     = PBAC_RUN;
               next_st.req_ready = 1'b0;
               next_st.write     = req_write;
               next_st.addr      = req_addr;
               next_st.rem       = req_len;
               // settings snapshot: a change mid-transfer waits for the next one
               next_st.wie   = st.access[`PBAC_WIE_BIT];
               next_st.rle   = st.access[`PBAC_RLE_BIT];
               next_st.rme   = st.access[`PBAC_RME_BIT];
               next_st.line  = line_of(st.access[`PBAC_ALIGN_MSB:`PBAC_ALIGN_LSB]);
               next_st.burst = st.access[`PBAC_BURST_MSB:`PBAC_BURST_LSB];
            end else if (req_valid && st.req_ready) begin
               // empty request: completes at once, nothing goes on the bus
               next_st.req_done = 1'b1;
            end
         end
         PBAC_RUN: begin
            // fifo ready is a flop, so the cut never waits on the bus master in the same cycle
            if (push_ready) begin
               next_st.addr = st.addr + {14'h0000, chunk, 2'b00};
               next_st.rem  = st.rem - chunk;
               if (st.rem == chunk) begin
                  next_st.state     = PBAC_IDLE;
                  next_st.req_ready = 1'b1;
                  next_st.req_done  = 1'b1;
               end
            end
         end
         default: begin
            next_st.state     = PBAC_IDLE;
            next_st.req_ready = 1'b1;
         end
      endcase

      // auto-poll timer restarts whenever the code changes or transmit resumes
      next_st.poll      = 1'b0;
      next_st.poll_code = st.access[`PBAC_POLL_MSB:`PBAC_POLL_LSB];
      if (!tx_suspended || (st.poll_code == `PBAC_POLL_OFF) ||
          (st.poll_code != st.access[`PBAC_POLL_MSB:`PBAC_POLL_LSB])) begin
         next_st.poll_cnt = `PBAC_POLL_CNT_W'(0);
      end else if (st.poll_cnt >= poll_limit(st.poll_code)) begin
         next_st.poll_cnt = `PBAC_POLL_CNT_W'(0);
         next_st.poll     = 1'b1;
      end else begin
         next_st.poll_cnt = st.poll_cnt + `PBAC_POLL_CNT_W'(1);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         // the splitter leaves reset idle and ready for its first request
         st           <= '0;
         st.access    <= `PBAC_ACCESS_RST;
         st.state     <= PBAC_IDLE;
         st.req_ready <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // four bursts of slack so the splitter runs ahead of the bus master
   pbac_fifo #(
      .WIDTH ($bits(pbac_burst_t)),
      .DEPTH (`PBAC_FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .nrst      (nrst),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (push_word),
      .out_valid (head_valid),
      .out_ready (bst_ready),
      .out_data  (head_word)
   );

   assign csr_rdata = st.rdata;
   assign csr_ack   = st.ack;
   assign req_ready = st.req_ready;
   assign req_done  = st.req_done;
   assign bst_valid = head_valid;
   assign bst_cmd   = head_word.cmd;
   assign bst_addr  = head_word.addr;
   assign bst_len   = head_word.len;
   assign tx_poll   = st.poll;

endmodule : pbac_top

`default_nettype wire

// >>> test/pbac_properties.sv
/*
 concurrent checks on the ports of pbac_top, bound into every instance.
 assumes one clk domain with asynchronous active-low nrst.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pbac_defs.svh"

module pbac_properties (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        csr_sel,
   input wire logic        csr_wr,
   input wire logic [7:0]  csr_addr,
   input wire logic [31:0] csr_rdata,
   input wire logic        csr_ack,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic [15:0] req_len,
   input wire logic        bst_valid,
   input wire logic        bst_ready,
   input wire logic [3:0]  bst_cmd,
   input wire logic [31:0] bst_addr,
   input wire logic [15:0] bst_len,
   input wire logic        tx_suspended,
   input wire logic        tx_poll
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   a_ack_after_sel: assert property (csr_sel |=> csr_ack) else $error("access not acknowledged");
   a_ack_one_pulse: assert property (!csr_sel |=> !csr_ack) else $error("ack without access");
   a_unmapped_zero: assert property (csr_sel && !csr_wr && csr_addr != 8'h00 |=> csr_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_mwi_full_line: assert property (bst_valid && bst_cmd == `PBAC_CMD_MWI |->
      bst_len inside {16'h8, 16'h10, 16'h20} && (bst_addr[7:2] & (bst_len[5:0] - 6'h1)) == 6'h0)
      else $error("write-invalidate on partial line");
   a_mrm_full_line: assert property (bst_valid && bst_cmd == `PBAC_CMD_MRM |->
      bst_len inside {16'h8, 16'h10, 16'h20} && (bst_addr[7:2] & (bst_len[5:0] - 6'h1)) == 6'h0)
      else $error("read multiple on partial line");
   a_mrl_line_end: assert property (bst_valid && bst_cmd == `PBAC_CMD_MRL |->
      ((bst_addr[7:2] + bst_len[5:0]) & 6'h7) == 6'h0) else $error("read line not ending on boundary");
   a_cmd_known: assert property (bst_valid |-> bst_cmd inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf})
      else $error("unknown bus command");
   a_burst_held: assert property (bst_valid && !bst_ready |=> bst_valid && $stable(bst_cmd)
      && $stable(bst_addr) && $stable(bst_len)) else $error("burst changed while stalled");
   a_busy_after_take: assert property (req_valid && req_ready && req_len != 16'h0 |=> !req_ready)
      else $error("request taken while splitting");
   a_poll_when_susp: assert property (tx_poll |-> $past(tx_suspended)) else $error("poll while running");
   a_burst_nonzero: assert property (bst_valid |-> bst_len != 16'h0) else $error("empty burst");
   a_poll_one_cycle: assert property (tx_poll |=> !tx_poll) else $error("poll pulse too long");
endmodule : pbac_properties

bind pbac_top pbac_properties u_pbac_properties (
   .clk(clk), .nrst(nrst), .csr_sel(csr_sel), .csr_wr(csr_wr), .csr_addr(csr_addr), .csr_rdata(csr_rdata),
   .csr_ack(csr_ack), .req_valid(req_valid), .req_ready(req_ready), .req_len(req_len), .bst_valid(bst_valid),
   .bst_ready(bst_ready), .bst_cmd(bst_cmd), .bst_addr(bst_addr), .bst_len(bst_len),
   .tx_suspended(tx_suspended), .tx_poll(tx_poll));

`default_nettype wire

// >>> test/pbac_sink.sv
/*
 bus-master side model: takes bursts with valid/ready and logs them.
 assumes stall holds ready low, slow gives ready every other cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module pbac_sink (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        stall,
   input  wire logic        slow,
   input  wire logic        bst_valid,
   output var  logic        bst_ready,
   input  wire logic [3:0]  bst_cmd,
   input  wire logic [31:0] bst_addr,
   input  wire logic [15:0] bst_len
);
   logic [51:0] got[$];
   logic        phase;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bst_ready <= 1'b0;
         phase <= 1'b0;
      end else begin
         if (bst_valid && bst_ready)
            got.push_back({bst_cmd, bst_addr, bst_len});
         phase <= !phase;
         bst_ready <= !stall && (!slow || phase);
      end
   end
endmodule : pbac_sink

`default_nettype wire

// >>> test/tb.sv
/*
 self-checking bench for pbac_top: register access, burst splitting, fifo stall, auto-poll.
 assumes pbac_sink as the bus master and short poll parameters.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic        clk, nrst, csr_sel, csr_wr, csr_ack, req_valid, req_ready, req_write, req_done;
   logic        bst_valid, bst_ready, tx_suspended, tx_poll, stall, slow;
   logic [7:0]  csr_addr;
   logic [3:0]  csr_be, bst_cmd;
   logic [31:0] csr_wdata, csr_rdata, req_addr, bst_addr;
   logic [15:0] req_len, bst_len;
   int          num_errors, num_checks, dones;
   int          per_list[6] = '{1, 2, 4, 8, 16, 32};

   pbac_top #(.POLL_SHORT_CYC(20), .POLL_MID_CYC(80), .POLL_LONG_CYC(160)) u_pbac_top (
      .clk(clk), .nrst(nrst), .csr_sel(csr_sel), .csr_wr(csr_wr), .csr_addr(csr_addr), .csr_be(csr_be),
      .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .csr_ack(csr_ack), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_len(req_len),
      .req_done(req_done), .bst_valid(bst_valid), .bst_ready(bst_ready), .bst_cmd(bst_cmd),
      .bst_addr(bst_addr), .bst_len(bst_len), .tx_suspended(tx_suspended), .tx_poll(tx_poll));
   pbac_sink u_pbac_sink (.clk(clk), .nrst(nrst), .stall(stall), .slow(slow), .bst_valid(bst_valid),
      .bst_ready(bst_ready), .bst_cmd(bst_cmd), .bst_addr(bst_addr), .bst_len(bst_len));

   always #5 clk = ~clk;
   // counted off the edge so the registered pulse is settled when looked at
   always @(negedge clk) if (req_done === 1'b1) dones++;

   task automatic chk(string what, logic [51:0] seen, logic [51:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : tally_and_finish

   task automatic csr(logic wr, logic [7:0] a, logic [3:0] be, logic [31:0] d, output logic [31:0] q);
      @(negedge clk);
      csr_sel = 1'b1;
      csr_wr = wr;
      csr_addr = a;
      csr_be = be;
      csr_wdata = d;
      @(negedge clk);
      csr_sel = 1'b0;
      q = csr_rdata;
      chk("ack", csr_ack, 1);
   endtask : csr

   task automatic t_regs;
      logic [31:0] q;
      csr(0, 8'h00, 4'hf, 32'h0, q);
      chk("reset value", q, 0);
      csr(1, 8'h00, 4'hf, 32'hffff_ffff, q);
      csr(0, 8'h00, 4'hf, 32'h0, q);
      chk("writable bits", q, 32'h01a6_ff00);
      csr(1, 8'h00, 4'h2, 32'h0, q);
      csr(1, 8'h08, 4'hf, 32'hffff_ffff, q);
      csr(0, 8'h08, 4'hf, 32'h0, q);
      chk("unmapped read", q, 0);
      csr(0, 8'h00, 4'hf, 32'h0, q);
      chk("byte enable", q, 32'h01a6_0000);
   endtask : t_regs

   task automatic t_dma(logic [31:0] cfg, logic wr, logic [31:0] a, int len, int hold);
      logic [51:0] exp[$];
      logic [31:0] q;
      logic [3:0]  c;
      int          lsz, max_burst_doublewords, n, d, left, i, d0;
      logic        full;
      csr(1, 8'h00, 4'hf, cfg, q);
      lsz = cfg[15:14] == 2'h0 ? 0 : 4 << cfg[15:14];
      max_burst_doublewords = int'(cfg[13:8]);
      d = int'(a[31:2]);
      left = len;
      while (left > 0) begin
         n = left;
         if (lsz != 0 && n > lsz - d % lsz) n = lsz - d % lsz;
         if (max_burst_doublewords != 0 && n > max_burst_doublewords) n = max_burst_doublewords;
         full = lsz != 0 && d % lsz == 0 && n == lsz;
         if (wr) c = cfg[24] && full ? 4'hf : 4'h7;
         else c = cfg[21] && full ? 4'hc : cfg[23] && lsz != 0 && (d + n) % lsz == 0 ? 4'he : 4'h6;
         exp.push_back({c, 32'(d * 4), 16'(n)});
         d += n;
         left -= n;
      end
      u_pbac_sink.got.delete();
      d0 = dones;
      stall = hold > 0;
      @(negedge clk);
      req_valid = 1'b1;
      req_write = wr;
      req_addr = a;
      req_len = 16'(len);
      while (req_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      repeat (hold) @(negedge clk);
      // four bursts fill the fifo, so the splitter must still be busy
      if (hold > 0) chk("stalled", {req_ready, 16'(u_pbac_sink.got.size())}, 0);
      stall = 1'b0;
      for (i = 0; i < 300 && (req_ready !== 1'b1 || bst_valid !== 1'b0); i++) @(negedge clk);
      chk("drained", 52'(i < 300), 1);
      repeat (2) @(negedge clk);
      chk("done pulses", 52'(dones - d0), 1);
      chk("burst count", 52'(u_pbac_sink.got.size()), 52'(exp.size()));
      for (i = 0; i < exp.size(); i++)
         chk("burst", i < u_pbac_sink.got.size() ? u_pbac_sink.got[i] : 'x, exp[i]);
   endtask : t_dma

   task automatic t_poll;
      logic [31:0] q;
      int          per[4] = '{-1, 20, 80, 160};
      int          c, i, first, gap;
      for (c = 0; c < 4; c++) begin
         csr(1, 8'h00, 4'hf, 32'(c) << 17, q);
         tx_suspended = 1'b1;
         first = -1;
         gap = -1;
         for (i = 0; i < 400; i++) begin
            @(negedge clk);
            if (tx_poll === 1'b1 && first >= 0 && gap < 0) gap = i - first;
            if (tx_poll === 1'b1 && first < 0) first = i;
         end
         tx_suspended = 1'b0;
         chk("poll first", 52'(first), 52'(per[c]));
         chk("poll interval", 52'(gap), 52'(per[c]));
      end
   endtask : t_poll

   initial begin
      {clk, nrst, csr_sel, csr_wr, req_valid, req_write, tx_suspended, stall, slow} = '0;
      {csr_addr, csr_be, csr_wdata, req_addr, req_len} = '0;
      repeat (16) @(negedge clk);
      nrst = 1'b1;
      t_regs();
      t_dma(32'h0100_4000, 1, 32'h4, 20, 0);
      t_dma(32'h0000_4000, 1, 32'h4, 20, 0);
      t_dma(32'h0080_8000, 0, 32'h10, 40, 0);
      t_dma(32'h0020_c000, 0, 32'h0, 40, 0);
      t_dma(32'h01a0_0000, 0, 32'h0, 40, 0);
      t_dma(32'h0100_4000, 1, 32'h0, 64, 20);
      foreach (per_list[k]) t_dma(32'h0100_8000 | (32'(per_list[k]) << 8), 1, 32'h0, 32, 0);
      t_dma(32'h0100_4000, 1, 32'h0, 0, 0);
      slow = 1'b1;
      t_dma(32'h00a0_c000, 0, 32'h40, 40, 0);
      slow = 1'b0;
      t_poll();
      tally_and_finish();
   end

   initial begin
      repeat (50000) @(posedge clk);
      num_errors++;
      tally_and_finish();
   end
endmodule : tb

`default_nettype wire
